// file: dmp_map.svh
`ifndef DMP_MAP_SVH
`define DMP_MAP_SVH
// register offsets (word addresses on the plain port)
`define DMP_ADDR_CTRL 4'h0
`define DMP_ADDR_DELAY 4'h1
`define DMP_ADDR_EQ 4'h2
`define DMP_ADDR_THRESH 4'h3
`define DMP_ADDR_COMP_GAIN 4'h4
`define DMP_ADDR_STATUS 4'h5
`define DMP_ADDR_NULL 4'h6
// ctrl fields
`define DMP_CTRL_MODE_LSB 0
`define DMP_CTRL_RATE_BIT 2
// reset values
`define DMP_CTRL_RST 32'h0000_0000
`define DMP_DELAY_RST 5'h01
`define DMP_EQ_RST 4'h0
`define DMP_THRESH_RST 20'h00400
`define DMP_COMP_GAIN_RST 16'h4000
// adaptive weight limits, q1.14: 0 gives 90 degree null, 1.0 gives 180 degree null
`define DMP_W_MIN 16'sh0000
`define DMP_W_MAX 16'sh4000
`define DMP_W_OMNI_LIM 16'sh0010
`define DMP_MU_SHIFT 12
// omni state recheck interval in samples
`define DMP_RECHECK_SAMPLES 16'd512
`define DMP_LEVEL_SHIFT 6
`endif

// file: dmp_pkg.sv
package dmp_pkg;
  typedef enum logic [1:0] {
    DMP_OMNI = 2'h0,
    DMP_STATIC = 2'h1,
    DMP_ADAPT = 2'h2,
    DMP_AUTO = 2'h3
  } dmp_mode_t;
  typedef enum logic [1:0] {
    DMP_ST_DIR = 2'b01,
    DMP_ST_OMNI = 2'b10
  } dmp_auto_t;
endpackage

// file: dmp_directional.sv
// Overview of operation
// - takes front and rear sample streams, outputs one directional stream
// - static output equals front minus delayed rear sample
// - rear delay is software configurable, shaping the polar pattern
// - fixed calibrated compensation gain on rear path in every directional mode
// - low frequency boost one-pole shelf after combiner, programmable amount
// - adaptive mode steers one null to minimise output power
// - adaptive null held between 90 and 180 degrees, never in front
// - front sound passes, rear sound attenuated; direction only
// - auto mode stays adaptive while level above threshold and not omni
// - auto mode drops to single mic omni when quiet or converged omni
// - omni state rechecks re-entry conditions at a regular interval
// - inputs are 20-bit samples at 32 kHz or 16 kHz
// - combination fixed in static mode, adapting in adaptive modes
`include "dmp_map.svh"
module dmp_directional
  import dmp_pkg::*;
#(
  parameter int SW = 20,
  parameter int MAXDLY = 32
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic sampleValid,
  input wire logic signed [SW-1:0] frontSample,
  input wire logic signed [SW-1:0] rearSample,
  output logic outValid,
  output logic signed [SW-1:0] outSample,
  output logic rearMicEnable,
  output logic rate16k
);
  // elaboration check; the write pointer wraps freely, so the line length must be a power of two
  if (SW < 8 || SW > 24 || MAXDLY < 2 || MAXDLY > 32 || (1 << $clog2(MAXDLY)) != MAXDLY) begin : gParamCheck
    $error("dmp_directional: unsupported parameters");
  end

  localparam int AW = $clog2(MAXDLY);
  localparam int XW = SW + 4;

  // configuration registers and internal state
  dmp_mode_t mode_q;
  logic rate16k_q;
  logic [4:0] delay_q;
  logic [3:0] eq_q;
  logic [19:0] thresh_q;
  logic signed [15:0] compGain_q;
  dmp_auto_t autoSt_q;
  logic signed [15:0] w_q;
  logic [XW-1:0] level_q;
  logic [15:0] recheck_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= DMP_OMNI;
      rate16k_q <= 1'b0;
      delay_q <= `DMP_DELAY_RST;
      eq_q <= `DMP_EQ_RST;
      thresh_q <= `DMP_THRESH_RST;
      compGain_q <= `DMP_COMP_GAIN_RST;
    end else if (regWr) begin
      if (regAddr == `DMP_ADDR_CTRL) begin
        mode_q <= dmp_mode_t'(regWdata[`DMP_CTRL_MODE_LSB +: 2]);
        rate16k_q <= regWdata[`DMP_CTRL_RATE_BIT];
      end else if (regAddr == `DMP_ADDR_DELAY) begin
        delay_q <= (regWdata[4:0] > 5'(MAXDLY - 1)) ? 5'(MAXDLY - 1) : regWdata[4:0];
      end else if (regAddr == `DMP_ADDR_EQ) begin
        eq_q <= regWdata[3:0];
      end else if (regAddr == `DMP_ADDR_THRESH) begin
        thresh_q <= regWdata[19:0];
      end else if (regAddr == `DMP_ADDR_COMP_GAIN) begin
        // loaded once at calibration, never adapted
        compGain_q <= regWdata[15:0];
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 32'h0;
    end else if (regRd) begin
      if (regAddr == `DMP_ADDR_CTRL) begin
        regRdata <= {29'h0, rate16k_q, mode_q};
      end else if (regAddr == `DMP_ADDR_DELAY) begin
        regRdata <= {27'h0, delay_q};
      end else if (regAddr == `DMP_ADDR_EQ) begin
        regRdata <= {28'h0, eq_q};
      end else if (regAddr == `DMP_ADDR_THRESH) begin
        regRdata <= {12'h0, thresh_q};
      end else if (regAddr == `DMP_ADDR_COMP_GAIN) begin
        regRdata <= {16'h0, compGain_q};
      end else if (regAddr == `DMP_ADDR_STATUS) begin
        regRdata <= {30'h0, autoSt_q == DMP_ST_OMNI, rearMicEnable};
      end else if (regAddr == `DMP_ADDR_NULL) begin
        regRdata <= {16'h0, w_q};
      end else begin
        regRdata <= 32'h0;
      end
    end else begin
      regRdata <= 32'h0;
    end
  end

  // rear delay line; inputs come from same-clock decimators, no sync needed
  logic signed [SW-1:0] rearLine [MAXDLY];
  logic [AW-1:0] wrPtr_q;
  always_ff @(posedge mclk) begin
    if (sampleValid) begin
      rearLine[wrPtr_q] <= rearSample;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= '0;
    end else if (sampleValid) begin
      wrPtr_q <= wrPtr_q + 1'b1;
    end
  end

  // tap read at configured delay, zero delay reads the live sample
  logic signed [SW-1:0] rearDly;
  logic [AW-1:0] rdPtr;
  always_comb begin
    rdPtr = wrPtr_q - delay_q[AW-1:0];
    rearDly = (delay_q == 5'h0) ? rearSample : rearLine[rdPtr];
  end

  // compensation gain q1.14 on rear path
  logic signed [SW+15:0] rearProd;
  logic signed [XW-1:0] rearComp;
  logic signed [XW-1:0] frontX;
  always_comb begin
    rearProd = rearDly * compGain_q;
    rearComp = XW'(rearProd >>> 14);
    frontX = XW'(frontSample);
  end

  // adaptive weight scales the delayed rear; 0..1 keeps null at rear
  logic signed [XW+15:0] wProd;
  logic signed [XW-1:0] combStatic;
  logic signed [XW-1:0] combAdapt;
  logic signed [XW-1:0] comb;
  logic dirActive;
  always_comb begin
    wProd = rearComp * w_q;
    combStatic = frontX - rearComp;
    combAdapt = frontX - XW'(wProd >>> 14);
    dirActive = (mode_q == DMP_STATIC) || (mode_q == DMP_ADAPT) ||
                (mode_q == DMP_AUTO && autoSt_q == DMP_ST_DIR);
    // static fixed, adaptive modes use steered weight
    if (mode_q == DMP_STATIC) begin
      comb = combStatic;
    end else if (dirActive) begin
      comb = combAdapt;
    end else begin
      comb = frontX;
    end
  end

  // sign lms on weight, minimising output power
  logic adaptOn;
  logic signed [XW-1:0] wStep;
  logic signed [16:0] wNext;
  always_comb begin
    adaptOn = (mode_q == DMP_ADAPT) || (mode_q == DMP_AUTO && autoSt_q == DMP_ST_DIR);
    wStep = (comb ^ rearComp) >>> (XW - 1 - `DMP_MU_SHIFT);
    wNext = 17'(w_q) + ((comb[XW-1] == rearComp[XW-1]) ? 17'sd4 : -17'sd4);
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      w_q <= `DMP_W_MAX;
    end else if (mode_q == DMP_AUTO && autoSt_q == DMP_ST_OMNI) begin
      // restart from rear null, else a converged weight blocks re-entry
      w_q <= `DMP_W_MAX;
    end else if (sampleValid && adaptOn && wStep != '0) begin
      // clamp keeps null between 90 and 180 degrees
      if (wNext > 17'(`DMP_W_MAX)) begin
        w_q <= `DMP_W_MAX;
      end else if (wNext < 17'(`DMP_W_MIN)) begin
        w_q <= `DMP_W_MIN;
      end else begin
        w_q <= wNext[15:0];
      end
    end
  end

  // ambient level, leaky average of front magnitude
  logic [XW-1:0] absFront;
  always_comb begin
    absFront = frontX[XW-1] ? XW'(-frontX) : frontX;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      level_q <= '0;
    end else if (sampleValid) begin
      level_q <= level_q - (level_q >> `DMP_LEVEL_SHIFT) + (absFront >> `DMP_LEVEL_SHIFT);
    end
  end

  // auto mode state machine
  logic loud;
  logic converged;
  always_comb begin
    loud = level_q > XW'(thresh_q);
    converged = w_q <= `DMP_W_OMNI_LIM;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      autoSt_q <= DMP_ST_DIR;
      recheck_q <= '0;
    end else if (mode_q != DMP_AUTO) begin
      autoSt_q <= DMP_ST_DIR;
      recheck_q <= '0;
    end else if (sampleValid) begin
      case (autoSt_q)
        DMP_ST_DIR: begin
          // stay while loud and not omni, else drop
          if (!loud || converged) begin
            autoSt_q <= DMP_ST_OMNI;
            recheck_q <= '0;
          end
        end
        DMP_ST_OMNI: begin
          // periodic recheck; weight restored so convergence test is fresh
          if (recheck_q == `DMP_RECHECK_SAMPLES - 16'd1) begin
            recheck_q <= '0;
            if (loud) begin
              autoSt_q <= DMP_ST_DIR;
            end
          end else begin
            recheck_q <= recheck_q + 16'd1;
          end
        end
        default: autoSt_q <= DMP_ST_DIR;
      endcase
    end
  end

  // one-pole shelf filter: boost lows by eq_q/4 of lowpassed signal
  logic signed [XW-1:0] lp_q;
  logic signed [XW+4:0] eqSum;
  always_comb begin
    eqSum = (XW+5)'(comb) + (((XW+5)'(lp_q) * $signed({1'b0, eq_q})) >>> 2);
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lp_q <= '0;
    end else if (sampleValid) begin
      lp_q <= lp_q + ((comb - lp_q) >>> 4);
    end
  end

  // single output stream, saturated to sample width
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      outValid <= 1'b0;
      outSample <= '0;
      rearMicEnable <= 1'b0;
      rate16k <= 1'b0;
    end else begin
      outValid <= sampleValid;
      rearMicEnable <= dirActive;
      rate16k <= rate16k_q;
      if (sampleValid) begin
        if (!dirActive) begin
          outSample <= frontSample;
        end else if (eqSum > (XW+5)'((1 <<< (SW-1)) - 1)) begin
          outSample <= SW'((1 <<< (SW-1)) - 1);
        end else if (eqSum < -(XW+5)'(1 <<< (SW-1))) begin
          outSample <= SW'(-(1 <<< (SW-1)));
        end else begin
          outSample <= eqSum[SW-1:0];
        end
      end
    end
  end

  // assertions
  a_out_valid_follows: assert property (@(posedge mclk) disable iff (!rstn)
    sampleValid |=> outValid) else $error("output valid missing");
  a_weight_in_range: assert property (@(posedge mclk) disable iff (!rstn)
    w_q >= `DMP_W_MIN && w_q <= `DMP_W_MAX) else $error("null outside rear range");
  a_static_fixed_weight: assert property (@(posedge mclk) disable iff (!rstn)
    mode_q == DMP_STATIC |=> $stable(w_q)) else $error("static weight moved");
  a_omni_passthru: assert property (@(posedge mclk) disable iff (!rstn)
    sampleValid && mode_q == DMP_OMNI |=> outSample == $past(frontSample)) else $error("omni not front");
  a_auto_drop_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    sampleValid && mode_q == DMP_AUTO && autoSt_q == DMP_ST_DIR && !loud |=> autoSt_q == DMP_ST_OMNI)
    else $error("auto did not drop");
  a_auto_hold_loud: assert property (@(posedge mclk) disable iff (!rstn)
    mode_q == DMP_AUTO && autoSt_q == DMP_ST_DIR && loud && !converged ##1 mode_q == DMP_AUTO
    |-> autoSt_q == DMP_ST_DIR) else $error("auto left while loud");
  a_recheck_bound: assert property (@(posedge mclk) disable iff (!rstn)
    recheck_q < `DMP_RECHECK_SAMPLES) else $error("recheck overrun");
  a_rear_mic_gate: assert property (@(posedge mclk) disable iff (!rstn)
    mode_q == DMP_OMNI ##1 mode_q == DMP_OMNI |-> !rearMicEnable) else $error("rear mic on in omni");
  c_static_run: cover property (@(posedge mclk) mode_q == DMP_STATIC && outValid);
  c_auto_drop: cover property (@(posedge mclk) autoSt_q == DMP_ST_DIR ##1 autoSt_q == DMP_ST_OMNI);
  c_auto_return: cover property (@(posedge mclk) autoSt_q == DMP_ST_OMNI ##1 autoSt_q == DMP_ST_DIR);
endmodule

// file: dmp_mic_model.sv
// front and rear decimator pair, one sample pair per period
module dmp_mic_model #(
  parameter int PERIOD = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic signed [19:0] frontIn,
  input wire logic signed [19:0] rearIn,
  output logic sampleValid,
  output logic signed [19:0] frontSample,
  output logic signed [19:0] rearSample
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // 20-bit pair, 16k rate doubles the period
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      sampleValid <= 1'b0;
      frontSample <= '0;
      rearSample <= '0;
    end else if (cnt >= (slow ? 2 * PERIOD : PERIOD) - 1) begin
      cnt <= 0;
      sampleValid <= 1'b1;
      frontSample <= frontIn;
      rearSample <= rearIn;
    end else begin
      // lines toggle between samples so stale data never looks valid
      cnt <= cnt + 1;
      sampleValid <= 1'b0;
      frontSample <= ~frontSample;
      rearSample <= ~rearSample;
    end
  end
endmodule

// file: directional_mic_processing_tb.sv
`include "dmp_map.svh"
module directional_mic_processing_tb import dmp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rstn = 0, regWr = 0, regRd = 0, rdSeen = 0, sampleValid;
  logic [3:0] regAddr = '0;
  logic [31:0] regWdata = '0, regRdata, seed = 32'd78;
  logic signed [19:0] frontSample, rearSample, outSample, frontIn = '0, rearIn = '0;
  logic outValid, rearMicEnable, rate16k;
  logic signed [19:0] sq[$], rh[$];
  logic [31:0] rq[$];
  logic signed [35:0] prod;
  int bad_count = 0, samples_checked = 0, curDly = 0;
  logic [15:0] curComp = 16'h4000;
  bit track = 0, quiet = 0, dcIn = 0;
  dmp_mode_t curMode = DMP_OMNI;
  always #2 mclk = ~mclk;
  dmp_directional uut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .sampleValid(sampleValid), .frontSample(frontSample),
    .rearSample(rearSample), .outValid(outValid), .outSample(outSample), .rearMicEnable(rearMicEnable),
    .rate16k(rate16k));
  dmp_mic_model mic (.mclk(mclk), .rstn(rstn), .slow(rate16k), .frontIn(frontIn), .rearIn(rearIn),
    .sampleValid(sampleValid), .frontSample(frontSample), .rearSample(rearSample));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // random pair each cycle, silence, or a dc front; rear kept even so half gain stays exact
  always @(posedge mclk) begin
    seed <= xs(seed);
    frontIn <= quiet ? 20'sh0 : dcIn ? 20'sh01000 : $signed(seed[19:0]) >>> 1;
    rearIn <= (quiet || dcIn) ? 20'sh0 : $signed({seed[31:14], 2'b0}) >>> 1;
  end
  always @(posedge mclk) rdSeen <= regRd;
  task automatic chkWord(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t word exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chkSample(input logic signed [19:0] e, input logic signed [19:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t sample exp %h got %h", $time, e, g);
    end
  endtask
  // monitor: oldest note against each answer
  always @(negedge mclk) begin
    if (rdSeen === 1'b1 && rq.size() > 0) chkWord(rq.pop_front(), regRdata);
    if (outValid === 1'b1 && sq.size() > 0) chkSample(sq.pop_front(), outSample);
    if (sampleValid === 1'b1) begin
      rh.push_front(rearSample);
      if (rh.size() > 8) void'(rh.pop_back());
      prod = rh[curDly] * $signed({20'h0, curComp});
      if (track && curMode == DMP_STATIC) sq.push_back(frontSample - 20'(prod >>> 14));
      if (track && curMode == DMP_OMNI) sq.push_back(frontSample);
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    rq.push_back(e);
    @(posedge mclk);
    regRd <= 1'b0;
  endtask
  // mode change: streams untracked until the delay line refills
  task automatic setMode(input logic [31:0] c, input int d, input logic [15:0] g);
    track = 0;
    wr(`DMP_ADDR_DELAY, d);
    wr(`DMP_ADDR_COMP_GAIN, {16'h0, g});
    wr(`DMP_ADDR_CTRL, c);
    rd(`DMP_ADDR_CTRL, c);
    curMode = dmp_mode_t'(c[1:0]);
    curDly = d;
    curComp = g;
    repeat (100) @(posedge mclk);
    track = 1;
    repeat (200) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic waitMic(input logic w, input int lim);
    int i;
    for (i = 0; i < lim && rearMicEnable !== w; i++) @(negedge mclk);
    chkWord({31'h0, w}, {31'h0, rearMicEnable});
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #240000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    // reset values, unmapped place ignores writes
    rd(`DMP_ADDR_CTRL, 32'h0);
    rd(`DMP_ADDR_DELAY, 32'h1);
    rd(`DMP_ADDR_EQ, 32'h0);
    rd(`DMP_ADDR_THRESH, 32'h400);
    rd(`DMP_ADDR_COMP_GAIN, 32'h4000);
    rd(`DMP_ADDR_NULL, 32'h4000);
    rd(`DMP_ADDR_STATUS, 32'h0);
    wr(4'h7, 32'hffff_ffff);
    rd(4'h7, 32'h0);
    wr(`DMP_ADDR_EQ, 32'h5);
    rd(`DMP_ADDR_EQ, 32'h5);
    wr(`DMP_ADDR_EQ, 32'h0);
    setMode(32'h0, 0, 16'h4000);
    chkWord(32'h0, {31'h0, rearMicEnable});
    setMode(32'h1, 0, 16'h4000);
    setMode(32'h1, 2, 16'h4000);
    setMode(32'h1, 3, 16'h2000);
    // dc front through static path, eq of 4 settles near twice the input
    dcIn = 1;
    setMode(32'h1, 1, 16'h4000);
    track = 0;
    wr(`DMP_ADDR_EQ, 32'h4);
    repeat (1200) @(posedge mclk);
    @(negedge mclk);
    chkWord(32'h1, {31'h0, outSample > 20'sh01f00 && outSample <= 20'sh02000});
    wr(`DMP_ADDR_EQ, 32'h0);
    dcIn = 0;
    setMode(32'h5, 1, 16'h4000);
    chkWord(32'h3, {30'h0, rate16k, rearMicEnable});
    setMode(32'h2, 1, 16'h4000);
    chkWord(32'h1, {31'h0, rearMicEnable});
    @(posedge mclk);
    regAddr <= `DMP_ADDR_NULL;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    // null stays between 90 and 180 degrees
    chkWord(32'h1, {31'h0, $signed(regRdata) <= 32'sh4000 && $signed(regRdata) >= 0});
    // uncorrelated rear pulls the weight off its reset value
    chkWord(32'h1, {31'h0, $signed(regRdata) < 32'sh4000});
    setMode(32'h3, 1, 16'h4000);
    chkWord(32'h1, {31'h0, rearMicEnable});
    quiet = 1;
    waitMic(1'b0, 9000);
    rd(`DMP_ADDR_STATUS, 32'h2);
    quiet = 0;
    waitMic(1'b1, 12000);
    finish_test();
  end
endmodule
